// file: design/ubs_defs.vh
`ifndef UBS_DEFS_VH
`define UBS_DEFS_VH
// Byte addresses, word aligned
`define UBS_A_MSTAT_BANK 6'h00
`define UBS_A_SCRATCH 6'h04
`define UBS_A_DIV_LO 6'h08
`define UBS_A_DIV_HI 6'h0C
`define UBS_A_TX_SPACE 6'h10
`define UBS_A_RX_FILL 6'h14
`define UBS_A_EFC 6'h18
`define UBS_A_RES1 6'h1C
`define UBS_A_RES2 6'h20
`define UBS_A_PAUSE1 6'h24
`define UBS_A_PAUSE2 6'h28
`define UBS_A_IEN 6'h2C
`define UBS_A_FCTL 6'h30
`define UBS_A_MCTL 6'h34
`define UBS_A_ISTAT 6'h38
// Bank select codes
`define UBS_BANK_GEN 2'h0
`define UBS_BANK_X1 2'h1
`define UBS_BANK_X2 2'h2
// Bank select control fields
`define UBS_BSC_LVL 0
`define UBS_BSC_BANK_LO 1
`define UBS_BSC_BANK_HI 2
// Enhanced feature control fields
`define UBS_EFC_CTS 7
`define UBS_EFC_RTS 6
`define UBS_EFC_SPEC 5
`define UBS_EFC_ENH 4
// Interrupt status bits
`define UBS_IS_RXTRIG 0
`define UBS_IS_MODEM 3
`define UBS_IS_SPEC 4
`define UBS_IS_CTS 5
// Enhanced bit masks
`define UBS_IEN_ENH 8'hF0
`define UBS_IS_ENH 8'h30
`define UBS_FCTL_ENH 8'h30
`define UBS_MCTL_ENH 8'hE0
// Reset values
`define UBS_RST_BYTE 8'h00
`define UBS_RST_DIV 8'h01
`endif

// file: design/ubs_regs.v
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ubs_defs.vh"

// Behaviour
// - Bank field 00 general set, 01 first extra set, 10 second set, 11 reserved.
// - Level-count enable bit makes tx space and rx fill counters readable.
// - Counters readable only while the bank field is zero.
// - Bank control is write-only; bits 7:3 reserved and ignored.
// - Scratch byte holds written data and affects nothing else.
// - High and low divisor latches form the 16-bit baud divisor.
// - Tx counter reads free transmit FIFO entries.
// - Rx counter reads characters held in receive FIFO.
// - Auto CTS halts transmitter while cts_n high, resumes when low.
// - Auto RTS interrupts at trigger, raises RTS above it, lowers below it.
// - Special detect compares received characters to second pause char, flags status bit 4.
// - Enhanced bits writable only while enhanced enable bit is one.
// - Enhanced enable bit activates retained enhanced FIFO and modem control settings; enhanced interrupt enables act regardless of it.
// - Low four bits select software flow control, default zero.
// - Mode 1111 matches first then second character as ordered pair; other receive mode 11 settings match either character.
// - Bits 3:2 pick transmit sets, bits 1:0 pick receive comparison.
// - Bank control shares address with modem status: reads status, writes control.
module ubs_regs (
  input wire clock, // 20 MHz
  input wire rst_n, // Async reset
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [5:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata_ff, // APB read data
  output reg pready_ff, // APB ready
  output reg pslverr_ff, // APB error
  input wire [7:0] tx_fifo_space, // Free tx entries
  input wire [7:0] rx_fifo_fill, // Held rx characters
  input wire [7:0] rx_trig_level, // Receive trigger level
  input wire rx_char_valid, // Received char pulse
  input wire [7:0] rx_char, // Received char
  input wire cts_n, // Pin, active low
  input wire dsr_n, // Pin, active low
  input wire ri_n, // Pin, active low
  input wire cd_n, // Pin, active low
  output reg rts_n_ff, // Pin, active low
  output reg tx_halt_ff, // Stop transmitter
  output reg [15:0] baud_div_ff, // Baud divisor
  output reg [3:0] sw_flow_sel_ff, // Software flow select
  output reg [7:0] enh_ctl_ff, // Effective enhanced bits
  output reg rx_pause_seen_ff, // Pause char(s) matched
  output reg rx_resume_seen_ff, // Resume char(s) matched
  output reg irq_ff // Level interrupt
);

  reg [2:0] bank_ctl_ff;
  reg [7:0] scratch_ff;
  reg [7:0] div_lo_ff;
  reg [7:0] div_hi_ff;
  reg [7:0] efc_ff;
  reg [7:0] res1_ff;
  reg [7:0] res2_ff;
  reg [7:0] pause1_ff;
  reg [7:0] pause2_ff;
  reg [7:0] ien_ff;
  reg [7:0] fctl_ff;
  reg [7:0] mctl_ff;
  reg [7:0] istat_ff;
  reg [3:0] mdelta_ff;
  reg pause_half_ff;
  reg resume_half_ff;
  reg rx_above_ff;
  reg [7:0] nxt_rdata;
  reg nxt_err;
  wire setup = psel & ~penable & ~pready_ff;
  wire access = psel & penable & pready_ff;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire [1:0] bank = bank_ctl_ff[`UBS_BSC_BANK_HI:`UBS_BSC_BANK_LO];
  wire enh = efc_ff[`UBS_EFC_ENH];
  wire [7:0] wb = pwdata[7:0];
  // Pin order: 0 cts, 1 dsr, 2 ri, 3 cd
  wire [3:0] pin_raw = {cd_n, ri_n, dsr_n, cts_n};
  wire [3:0] pin_stable;
  wire [3:0] pin_ff;
  ubs_sync3 #(.WIDTH(4)) pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din(pin_raw),
    .settled(pin_stable),
    .level_ff(pin_ff)
  );
  wire [3:0] pin_chg = pin_stable ^ pin_ff;
  wire [3:0] mdelta_set = {pin_chg[3], pin_chg[2] & pin_stable[2], pin_chg[1:0]};
  wire mstat_rd = rd & (paddr == `UBS_A_MSTAT_BANK);
  wire in_gen = (bank == `UBS_BANK_GEN);
  wire in_x1 = (bank == `UBS_BANK_X1);
  wire in_x2 = (bank == `UBS_BANK_X2);
  wire lvl_on = in_gen & bank_ctl_ff[`UBS_BSC_LVL];
  wire [8:0] trig_p1 = {1'b0, rx_trig_level} + 9'h001;
  wire rx_at_trig = (rx_fifo_fill >= rx_trig_level);
  wire rx_over = ({1'b0, rx_fifo_fill} >= trig_p1);
  wire rx_under = (rx_fifo_fill < rx_trig_level);
  reg rx_at_trig_d_ff;
  // Receive flow comparisons
  wire [1:0] rsel = sw_flow_sel_ff[1:0];
  wire pair_mode = (rsel == 2'h3) & (sw_flow_sel_ff[3:2] == 2'h3);
  wire hit_p1 = (rx_char == pause1_ff);
  wire hit_p2 = (rx_char == pause2_ff);
  wire hit_r1 = (rx_char == res1_ff);
  wire hit_r2 = (rx_char == res2_ff);
  reg pause_hit;
  reg resume_hit;
  reg [7:0] ev;
  wire [7:0] ien_merged;
  wire [7:0] fctl_merged;
  wire [7:0] mctl_merged;

  ubs_enh_keep #(.MASK(`UBS_IEN_ENH)) keep_ien (
    .enh(enh),
    .wr_byte(wb),
    .cur_byte(ien_ff),
    .merged(ien_merged)
  );
  ubs_enh_keep #(.MASK(`UBS_FCTL_ENH)) keep_fctl (
    .enh(enh),
    .wr_byte(wb),
    .cur_byte(fctl_ff),
    .merged(fctl_merged)
  );
  ubs_enh_keep #(.MASK(`UBS_MCTL_ENH)) keep_mctl (
    .enh(enh),
    .wr_byte(wb),
    .cur_byte(mctl_ff),
    .merged(mctl_merged)
  );

  // Register read mux, registered in the setup cycle
  always @* begin
    nxt_rdata = 8'h00;
    nxt_err = 1'b0;
    case (paddr)
      `UBS_A_MSTAT_BANK: nxt_rdata = {~pin_ff, mdelta_ff};
      `UBS_A_SCRATCH: nxt_rdata = scratch_ff;
      `UBS_A_DIV_LO: nxt_rdata = in_x1 ? div_lo_ff : 8'h00;
      `UBS_A_DIV_HI: nxt_rdata = in_x1 ? div_hi_ff : 8'h00;
      `UBS_A_TX_SPACE: nxt_rdata = lvl_on ? tx_fifo_space : 8'h00;
      `UBS_A_RX_FILL: nxt_rdata = lvl_on ? rx_fifo_fill : 8'h00;
      `UBS_A_EFC: nxt_rdata = in_x2 ? efc_ff : 8'h00;
      `UBS_A_RES1: nxt_rdata = in_x2 ? res1_ff : 8'h00;
      `UBS_A_RES2: nxt_rdata = in_x2 ? res2_ff : 8'h00;
      `UBS_A_PAUSE1: nxt_rdata = in_x2 ? pause1_ff : 8'h00;
      `UBS_A_PAUSE2: nxt_rdata = in_x2 ? pause2_ff : 8'h00;
      `UBS_A_IEN: nxt_rdata = ien_ff;
      `UBS_A_FCTL: nxt_rdata = fctl_ff;
      `UBS_A_MCTL: nxt_rdata = mctl_ff;
      `UBS_A_ISTAT: nxt_rdata = istat_ff;
      default: nxt_err = 1'b1;
    endcase
  end

  // APB handshake: one wait-free access phase after each setup
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & nxt_err;
      if (setup) begin
        prdata_ff <= {24'h000000, nxt_rdata};
      end
    end
  end

  // Software-written registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank_ctl_ff <= 3'h0;
      scratch_ff <= `UBS_RST_BYTE;
      div_lo_ff <= `UBS_RST_DIV;
      div_hi_ff <= `UBS_RST_BYTE;
      efc_ff <= `UBS_RST_BYTE;
      res1_ff <= `UBS_RST_BYTE;
      res2_ff <= `UBS_RST_BYTE;
      pause1_ff <= `UBS_RST_BYTE;
      pause2_ff <= `UBS_RST_BYTE;
      ien_ff <= `UBS_RST_BYTE;
      fctl_ff <= `UBS_RST_BYTE;
      mctl_ff <= `UBS_RST_BYTE;
    end else if (wr) begin
      case (paddr)
        `UBS_A_MSTAT_BANK: bank_ctl_ff <= wb[2:0];
        `UBS_A_SCRATCH: scratch_ff <= wb;
        `UBS_A_DIV_LO: if (in_x1) div_lo_ff <= wb;
        `UBS_A_DIV_HI: if (in_x1) div_hi_ff <= wb;
        `UBS_A_EFC: if (in_x2) efc_ff <= wb;
        `UBS_A_RES1: if (in_x2) res1_ff <= wb;
        `UBS_A_RES2: if (in_x2) res2_ff <= wb;
        `UBS_A_PAUSE1: if (in_x2) pause1_ff <= wb;
        `UBS_A_PAUSE2: if (in_x2) pause2_ff <= wb;
        // Enhanced bits keep their value unless the enable bit is set
        `UBS_A_IEN: ien_ff <= ien_merged;
        `UBS_A_FCTL: fctl_ff <= fctl_merged;
        `UBS_A_MCTL: mctl_ff <= mctl_merged;
        default: ;
      endcase
    end
  end

  // Receive character matching
  always @* begin
    pause_hit = 1'b0;
    resume_hit = 1'b0;
    case (rsel)
      2'h2: begin
        pause_hit = hit_p1;
        resume_hit = hit_r1;
      end
      2'h1: begin
        pause_hit = hit_p2;
        resume_hit = hit_r2;
      end
      2'h3: begin
        if (pair_mode) begin
          pause_hit = pause_half_ff & hit_p2;
          resume_hit = resume_half_ff & hit_r2;
        end else begin
          pause_hit = hit_p1 | hit_p2;
          resume_hit = hit_r1 | hit_r2;
        end
      end
      default: ;
    endcase
  end

  always @* begin
    ev = 8'h00;
    ev[`UBS_IS_RXTRIG] = efc_ff[`UBS_EFC_RTS] & rx_at_trig & ~rx_at_trig_d_ff;
    ev[`UBS_IS_MODEM] = |mdelta_set;
    ev[`UBS_IS_SPEC] = efc_ff[`UBS_EFC_SPEC] & rx_char_valid & hit_p2;
    ev[`UBS_IS_CTS] = efc_ff[`UBS_EFC_CTS] & pin_chg[0];
  end

  // Hardware-set state; a new event wins over a clear in the same cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      istat_ff <= 8'h00;
      mdelta_ff <= 4'h0;
      pause_half_ff <= 1'b0;
      resume_half_ff <= 1'b0;
      rx_at_trig_d_ff <= 1'b0;
      rx_above_ff <= 1'b0;
      rx_pause_seen_ff <= 1'b0;
      rx_resume_seen_ff <= 1'b0;
    end else begin
      if (wr & (paddr == `UBS_A_ISTAT)) begin
        istat_ff <= (istat_ff & ~(wb & (enh ? 8'hFF : ~`UBS_IS_ENH))) | ev;
      end else begin
        istat_ff <= istat_ff | ev;
      end
      mdelta_ff <= (mstat_rd ? 4'h0 : mdelta_ff) | mdelta_set;
      rx_at_trig_d_ff <= rx_at_trig;
      if (rx_over) begin
        rx_above_ff <= 1'b1;
      end else if (rx_under) begin
        rx_above_ff <= 1'b0;
      end
      rx_pause_seen_ff <= rx_char_valid & pause_hit;
      rx_resume_seen_ff <= rx_char_valid & resume_hit;
      if (rx_char_valid) begin
        pause_half_ff <= pair_mode & hit_p1;
        resume_half_ff <= pair_mode & hit_r1;
      end
    end
  end

  // Outputs toward the serial side
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rts_n_ff <= 1'b1;
      tx_halt_ff <= 1'b0;
      baud_div_ff <= {`UBS_RST_BYTE, `UBS_RST_DIV};
      sw_flow_sel_ff <= 4'h0;
      enh_ctl_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      tx_halt_ff <= efc_ff[`UBS_EFC_CTS] & pin_ff[0];
      // Software rts bit is modem control bit 1
      rts_n_ff <= efc_ff[`UBS_EFC_RTS] ? rx_above_ff : ~mctl_ff[1];
      baud_div_ff <= {div_hi_ff, div_lo_ff};
      sw_flow_sel_ff <= efc_ff[3:0];
      // Retained enhanced settings act only while enabled
      enh_ctl_ff <= enh ? {mctl_ff[7:5], fctl_ff[5:4], 3'h0} : 8'h00;
      irq_ff <= |(istat_ff & ien_ff);
    end
  end

endmodule // ubs_regs

module ubs_sync3 #(
  parameter WIDTH = 4
) (
  input wire clock, // Device clock
  input wire rst_n, // Async reset
  input wire [WIDTH-1:0] din, // Pin levels
  output wire [WIDTH-1:0] settled, // Agreed level
  output reg [WIDTH-1:0] level_ff // Last agreed level
);

  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;

  // A change counts only once stages two and three agree
  assign settled = (s2_ff == s3_ff) ? s3_ff : level_ff;

  // Idle high after reset, so no false edge follows it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= {WIDTH{1'b1}};
      s2_ff <= {WIDTH{1'b1}};
      s3_ff <= {WIDTH{1'b1}};
      level_ff <= {WIDTH{1'b1}};
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= settled;
    end
  end

endmodule // ubs_sync3

module ubs_enh_keep #(
  parameter [7:0] MASK = 8'hF0
) (
  input wire enh, // Enhanced write enable
  input wire [7:0] wr_byte, // Byte written
  input wire [7:0] cur_byte, // Byte held now
  output wire [7:0] merged // Next held byte
);

  // Masked bits stay frozen while enh is low so older software cannot disturb them
  assign merged = enh ? wr_byte : ((wr_byte & ~MASK) | (cur_byte & MASK));

endmodule // ubs_enh_keep
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ubs_defs.vh"
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  reg clock;
  reg rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  reg [5:0] paddr = 6'h00;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata_ff;
  wire [15:0] baud_div_ff;
  wire [7:0] tsp, rfl, trg, rch, enh_ctl_ff;
  wire [3:0] sw_flow_sel_ff;
  wire pready_ff, pslverr_ff, cts_n, dsr_n, ri_n, cd_n, rvl, rts_n_ff, tx_halt_ff, irq_ff, pse, rse;
  int n_fail = 0, n_compared = 0, n_pause = 0, n_resume = 0, i;
  logic [7:0] fl [5] = '{8'h03, 8'h04, 8'h05, 8'h04, 8'h03};
  logic ex [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  ubs_peer peer (.clock(clock), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n),
    .tx_fifo_space(tsp), .rx_fifo_fill(rfl), .rx_trig_level(trg), .rx_char_valid(rvl),
    .rx_char(rch));
  ubs_regs dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .tx_fifo_space(tsp), .rx_fifo_fill(rfl),
    .rx_trig_level(trg), .rx_char_valid(rvl), .rx_char(rch), .cts_n(cts_n), .dsr_n(dsr_n),
    .ri_n(ri_n), .cd_n(cd_n), .rts_n_ff(rts_n_ff), .tx_halt_ff(tx_halt_ff),
    .baud_div_ff(baud_div_ff), .sw_flow_sel_ff(sw_flow_sel_ff), .enh_ctl_ff(enh_ctl_ff),
    .rx_pause_seen_ff(pse), .rx_resume_seen_ff(rse), .irq_ff(irq_ff));
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (pse === 1'b1) n_pause++;
  always @(posedge clock) if (rse === 1'b1) n_resume++;
  task complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task xfer(input w, input [5:0] a, input [7:0] d, input [7:0] e, input err);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    // No wait count is assumed; the watchdog ends a hang
    do @(posedge clock); while (pready_ff !== 1'b1);
    `CMP(pslverr_ff, err)
    if (!w) `CMP(prdata_ff[7:0], e)
    {psel, penable} <= 2'b00;
  endtask
  task wr(input [5:0] a, input [7:0] d);
    xfer(1'b1, a, d, 8'h00, 1'b0);
  endtask
  task rd(input [5:0] a, input [7:0] e);
    xfer(1'b0, a, 8'h00, e, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    `CMP({rts_n_ff, baud_div_ff, sw_flow_sel_ff, irq_ff}, {1'b1, 16'h0001, 4'h0, 1'b0})
    rd(`UBS_A_MSTAT_BANK, 8'h00);
    rd(`UBS_A_TX_SPACE, 8'h00);
    peer.levels(8'h7D, 8'h05);
    wr(`UBS_A_MSTAT_BANK, 8'hF9);
    rd(`UBS_A_TX_SPACE, 8'h7D);
    wr(`UBS_A_TX_SPACE, 8'hFF);
    rd(`UBS_A_TX_SPACE, 8'h7D);
    rd(`UBS_A_RX_FILL, 8'h05);
    rd(`UBS_A_MSTAT_BANK, 8'h00);
    wr(`UBS_A_SCRATCH, 8'hA5);
    wr(`UBS_A_DIV_LO, 8'h34);
    xfer(1'b0, 6'h3C, 8'h00, 8'h00, 1'b1);
    wr(`UBS_A_MSTAT_BANK, 8'h03);
    rd(`UBS_A_TX_SPACE, 8'h00);
    rd(`UBS_A_DIV_LO, 8'h01);
    wr(`UBS_A_DIV_LO, 8'h34);
    wr(`UBS_A_DIV_HI, 8'h12);
    rd(`UBS_A_SCRATCH, 8'hA5);
    tick(2);
    `CMP(baud_div_ff, 16'h1234)
    wr(`UBS_A_MSTAT_BANK, 8'h06);
    rd(`UBS_A_DIV_LO, 8'h00);
    wr(`UBS_A_MSTAT_BANK, 8'h04);
    wr(`UBS_A_PAUSE1, 8'h11);
    wr(`UBS_A_PAUSE2, 8'h22);
    wr(`UBS_A_EFC, 8'h0F);
    rd(`UBS_A_EFC, 8'h0F);
    `CMP(sw_flow_sel_ff, 4'hF)
    peer.send(8'h22);
    peer.send(8'h11);
    tick(3);
    `CMP(n_pause, 0)
    peer.send(8'h11);
    peer.send(8'h22);
    tick(3);
    `CMP(n_pause, 1)
    wr(`UBS_A_RES1, 8'h33);
    wr(`UBS_A_EFC, 8'h02);
    peer.send(8'h11);
    peer.send(8'h22);
    tick(3);
    `CMP(n_pause, 2)
    peer.send(8'h33);
    tick(3);
    `CMP(n_resume, 1)
    wr(`UBS_A_EFC, 8'h10);
    wr(`UBS_A_EFC, 8'h30);
    wr(`UBS_A_IEN, 8'h10);
    peer.send(8'h21);
    tick(3);
    `CMP(irq_ff, 1'b0)
    peer.send(8'h22);
    tick(3);
    `CMP(irq_ff, 1'b1)
    rd(`UBS_A_ISTAT, 8'h10);
    wr(`UBS_A_IEN, 8'h00);
    tick(2);
    `CMP(irq_ff, 1'b0)
    wr(`UBS_A_IEN, 8'h10);
    tick(2);
    `CMP(irq_ff, 1'b1)
    wr(`UBS_A_ISTAT, 8'h10);
    tick(2);
    `CMP(irq_ff, 1'b0)
    wr(`UBS_A_MCTL, 8'hE0);
    tick(2);
    `CMP(enh_ctl_ff, 8'hE0)
    wr(`UBS_A_EFC, 8'h00);
    wr(`UBS_A_MCTL, 8'h00);
    wr(`UBS_A_EFC, 8'h10);
    tick(2);
    `CMP(enh_ctl_ff, 8'hE0)
    wr(`UBS_A_EFC, 8'h50);
    for (i = 0; i < 5; i++) begin
      peer.levels(8'h7D, fl[i]);
      tick(3);
      `CMP(rts_n_ff, ex[i])
    end
    peer.trig(8'h06);
    peer.levels(8'h7D, 8'h05);
    tick(3);
    `CMP(rts_n_ff, 1'b0)
    peer.levels(8'h7D, 8'h07);
    tick(3);
    `CMP(rts_n_ff, 1'b1)
    wr(`UBS_A_EFC, 8'h90);
    tick(8);
    `CMP(tx_halt_ff, 1'b1)
    peer.pins(4'h7);
    tick(8);
    `CMP(tx_halt_ff, 1'b0)
    rd(`UBS_A_MSTAT_BANK, 8'h11);
    rd(`UBS_A_MSTAT_BANK, 8'h10);
    peer.pins(4'h0);
    tick(8);
    rd(`UBS_A_MSTAT_BANK, 8'hFA);
    peer.pins(4'h7);
    tick(8);
    rd(`UBS_A_MSTAT_BANK, 8'h1E);
    complete_run;
  end
  initial begin
    #400000;
    n_fail++;
    complete_run;
  end
endmodule // testbench
bind ubs_regs ubs_chk chk (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata_ff, .pready_ff, .pslverr_ff, .tx_fifo_space, .rx_fifo_fill, .cts_n, .tx_halt_ff,
  .baud_div_ff);
`default_nettype wire

// file: tb/ubs_chk_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "ubs_defs.vh"
module ubs_chk (
  input wire clock, // Device clock
  input wire rst_n, // Async reset
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [5:0] paddr, // APB address
  input wire [31:0] pwdata, // APB write data
  input wire [31:0] prdata_ff, // APB read data
  input wire pready_ff, // APB ready
  input wire pslverr_ff, // APB error
  input wire [7:0] tx_fifo_space, // Free tx entries
  input wire [7:0] rx_fifo_fill, // Held rx chars
  input wire cts_n, // Send permission pin
  input wire tx_halt_ff, // Transmitter stop
  input wire [15:0] baud_div_ff // Divisor
);
  reg [2:0] sel_ff;
  wire done = psel && penable && pready_ff;
  wire wr = done && pwrite && !pslverr_ff;
  // Shadow of the write-only bank control, since it cannot be read back
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) sel_ff <= 3'h0;
    else if (wr && paddr == `UBS_A_MSTAT_BANK) sel_ff <= pwdata[2:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ready_setup: assert property (psel && !penable && !pready_ff |=> pready_ff)
    else $error("no ready after setup");
  a_ready_single: assert property (pready_ff |=> !pready_ff)
    else $error("ready held too long");
  a_unmapped_err: assert property (done && paddr == 6'h3C |-> pslverr_ff)
    else $error("unmapped access not refused");
  a_tx_level_gate: assert property (done && !pwrite && paddr == `UBS_A_TX_SPACE
    |-> prdata_ff[7:0] == (sel_ff == 3'h1 ? $past(tx_fifo_space) : 8'h00))
    else $error("tx space read wrong");
  a_rx_level_gate: assert property (done && !pwrite && paddr == `UBS_A_RX_FILL
    |-> prdata_ff[7:0] == (sel_ff == 3'h1 ? $past(rx_fifo_fill) : 8'h00))
    else $error("rx fill read wrong");
  a_div_low_out: assert property (wr && paddr == `UBS_A_DIV_LO && sel_ff[2:1] == 2'h1
    |-> ##2 baud_div_ff[7:0] == $past(pwdata[7:0], 2)) else $error("divisor low wrong");
  a_div_high_out: assert property (wr && paddr == `UBS_A_DIV_HI && sel_ff[2:1] == 2'h1
    |-> ##2 baud_div_ff[15:8] == $past(pwdata[7:0], 2)) else $error("divisor high wrong");
  a_cts_resume: assert property (!cts_n [*8] |-> !tx_halt_ff)
    else $error("halt while send permitted");
endmodule // ubs_chk
`default_nettype wire

// file: tb/ubs_peer.sv
`timescale 1ns/100ps
`default_nettype none
module ubs_peer (
  input wire clock, // Device clock
  output logic cts_n, // Send permission
  output logic dsr_n, // Ready
  output logic ri_n, // Ring
  output logic cd_n, // Carrier
  output logic [7:0] tx_fifo_space, // Free tx entries
  output logic [7:0] rx_fifo_fill, // Held rx chars
  output logic [7:0] rx_trig_level, // Rx trigger
  output logic rx_char_valid, // Char strobe
  output logic [7:0] rx_char // Char
);
  initial begin
    {cts_n, dsr_n, ri_n, cd_n} = 4'hF;
    {tx_fifo_space, rx_fifo_fill, rx_trig_level} = {8'h80, 8'h00, 8'h04};
    {rx_char_valid, rx_char} = 9'h000;
  end
  task pins(input [3:0] p);
    @(posedge clock);
    {cts_n, dsr_n, ri_n, cd_n} <= p;
  endtask
  task trig(input [7:0] t);
    @(posedge clock);
    rx_trig_level <= t;
  endtask
  task levels(input [7:0] s, input [7:0] f);
    @(posedge clock);
    {tx_fifo_space, rx_fifo_fill} <= {s, f};
  endtask
  task send(input [7:0] c);
    @(posedge clock);
    {rx_char_valid, rx_char} <= {1'b1, c};
    @(posedge clock);
    // Stale byte inverted so no match is ever made by leftovers
    {rx_char_valid, rx_char} <= {1'b0, ~c};
  endtask
endmodule // ubs_peer
`default_nettype wire
